// File: design/ivs_core.sv
// Interrupt recognition, vectoring and register stacking engine
`timescale 1ns/10ps
`default_nettype none

module ivs_core import ivs_pkg::*; #(
	parameter logic [255:0] OPMAP_P0 = OPMAP_ALL_LEGAL,
	parameter logic [255:0] OPMAP_P1 = OPMAP_ALL_LEGAL,
	parameter logic [255:0] OPMAP_P2 = OPMAP_ALL_LEGAL,
	parameter logic [255:0] OPMAP_P3 = OPMAP_ALL_LEGAL
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// CPU sequencer side
	input wire logic instr_done,
	input wire logic swi_done,
	input wire logic rti_req,
	input wire logic tap_req,
	input wire logic [7:0] tap_data,
	input wire ivs_regs_t cpu_regs,
	input wire ivs_opf_t op_fetch,
	// Memory access
	output ivs_mem_t mem_o,
	input wire logic [7:0] mem_rdata,
	// Results to the sequencer
	output logic take_done,
	output logic [15:0] new_pc,
	output logic [15:0] new_sp,
	output logic pop_done,
	output ivs_regs_t pop_regs,
	output logic mask_i,
	output logic mask_x,
	// Interrupt pins, active low
	input wire logic irq_n,
	input wire logic nonmaskable_irq_pin_n,
	// Peripheral flags and enables
	input wire ivs_flags_t pflags,
	input wire ivs_en_t pen,
	input wire logic watchdog_fail,
	input wire logic watchdog_disable,
	input wire logic clock_fail,
	input wire logic clock_monitor_en,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata
);

	// ******************************
	// Helper functions
	// ******************************

	// Map a promote code onto a position in the default order
	function automatic logic [3:0] psel_idx(input logic [3:0] p);
		if (p <= PSEL_LOW_LAST) begin
			return p + PSEL_LOW_OFS;
		end else if (p == PSEL_PIN_A || p == PSEL_PIN_B) begin
			return '0;
		end else begin
			return p - PSEL_HIGH_OFS;
		end
	endfunction

	// Lowest set position wins in the default order
	function automatic logic [3:0] first_set(input logic [N_MASK-1:0] r);
		logic [3:0] k;
		k = '0;
		for (int n = N_MASK - 1; n >= 0; n--) begin
			if (r[n]) begin
				k = 4'(n);
			end
		end
		return k;
	endfunction

	// Maskable vectors step down by two bytes from the pin vector
	function automatic logic [15:0] mask_vec(input logic [3:0] idx);
		return VEC_MASK_TOP - {11'h0, idx, 1'b0};
	endfunction

	// Opcode legality lookup by map page
	function automatic logic op_legal(input logic [1:0] pg,
		input logic [7:0] code);
		logic ok;
		ok = 1'b1;
		unique case (pg)
			2'h0: ok = OPMAP_P0[code];
			2'h1: ok = OPMAP_P1[code];
			2'h2: ok = OPMAP_P2[code];
			2'h3: ok = OPMAP_P3[code];
		endcase
		return ok;
	endfunction

	// ******************************
	// State and request decoding
	// ******************************
	ivs_state_t s_q, s_d;
	logic [N_MASK-1:0] mreq;
	logic [3:0] prom, pick;
	logic boundary, reset_class, take_nmi, take_msk, take_any, swi_now;
	logic [15:0] take_vec, ret_pc;
	logic [7:0] ccr_push, status;

	// Maskable requests in default order, pin first
	assign mreq = {
		(pflags.tx_done & pen.tx_done_irq_en) |
		(pflags.tx_empty & pen.tx_empty_irq_en) |
		(pflags.idle_line & pen.idle_line_irq_en) |
		((pflags.overrun | pflags.rx_full) & pen.rx_irq_en),
		pflags.spi_done & pen.serial_periph_irq_en,
		pflags.pulse_edge & pen.pulse_edge_irq_en,
		pflags.pulse_ovf & pen.pulse_overflow_irq_en,
		pflags.wrap & pen.timer_wrap_irq_en,
		pflags.cap4cmp5 & pen.capture4_compare5_irq_en,
		pflags.cmp4 & pen.compare4_irq_en,
		pflags.cmp3 & pen.compare3_irq_en,
		pflags.cmp2 & pen.compare2_irq_en,
		pflags.cmp1 & pen.compare1_irq_en,
		pflags.cap3 & pen.capture3_irq_en,
		pflags.cap2 & pen.capture2_irq_en,
		pflags.cap1 & pen.capture1_irq_en,
		pflags.tick & pen.periodic_tick_irq_en,
		~s_q.irq_s[1]
	};

	// Promoted source first, else fixed order
	assign prom = psel_idx(s_q.psel);
	assign pick = mreq[prom] ? prom : first_set(mreq);

	// Recognition terms
	assign boundary = instr_done | swi_done;
	assign reset_class = (clock_fail & clock_monitor_en) |
		(watchdog_fail & ~watchdog_disable);
	assign take_nmi = ~s_q.nonmaskable_irq_pin_s[1] & ~s_q.x;
	assign take_msk = (|mreq) & ~s_q.i;
	assign take_any = take_nmi | s_q.ill_pend | s_q.swi_pend | swi_done |
		take_msk;

	// A trap with nothing ahead of it is served at its own boundary
	assign swi_now = swi_done & ~take_nmi & ~s_q.ill_pend & ~s_q.swi_pend &
		(s_q.st == ST_IDLE);

	// Winning vector: pin, illegal, trap, then maskable
	always_comb begin
		if (take_nmi) begin
			take_vec = VEC_NMI;
		end else if (s_q.ill_pend) begin
			take_vec = VEC_ILLEGAL;
		end else if (s_q.swi_pend || swi_done) begin
			take_vec = VEC_SWTRAP;
		end else begin
			take_vec = mask_vec(pick);
		end
	end

	// Illegal trap returns to the offending opcode
	assign ret_pc = (!take_nmi && s_q.ill_pend) ? s_q.ill_addr : cpu_regs.pc;

	// Condition codes as pushed carry this block's mask bits
	always_comb begin
		ccr_push = cpu_regs.condition_code_reg;
		ccr_push[CCR_X_BIT] = s_q.x;
		ccr_push[CCR_I_BIT] = s_q.i;
	end

	// Status readback
	assign status = {s_q.x, s_q.i, s_q.ill_pend, s_q.swi_pend, 1'b0, s_q.st};

	// ******************************
	// Next-state logic
	// ******************************
	always_comb begin
		s_d = s_q;
		s_d.mem = '0;
		s_d.take_done = 1'b0;
		s_d.pop_done = 1'b0;
		s_d.rdata = '0;
		s_d.irq_s = {s_q.irq_s[0], irq_n};
		s_d.nonmaskable_irq_pin_s = {s_q.nonmaskable_irq_pin_s[0], nonmaskable_irq_pin_n};

		// Promote code only while maskable sources are held off
		if (reg_we && reg_addr == ADDR_PROMOTE && s_q.i) begin
			s_d.psel = reg_wdata[PSEL_MSB:0];
		end

		// Read data for the cycle after the strobe
		if (reg_re) begin
			if (reg_addr == ADDR_PROMOTE) begin
				s_d.rdata = {4'h0, s_q.psel};
			end else if (reg_addr == ADDR_STATUS) begin
				s_d.rdata = status;
			end
		end

		unique case (s_q.st)
			ST_IDLE: begin
				if (tap_req) begin
					s_d.i = tap_data[CCR_I_BIT];
					s_d.x = s_q.x & tap_data[CCR_X_BIT];
				end
				if (boundary && take_any) begin
					s_d.st = ST_PUSH;
					s_d.cnt = '0;
					s_d.sp = cpu_regs.sp;
					s_d.vec = take_vec;
					s_d.take_x = take_nmi;
					s_d.stk = {ccr_push, cpu_regs.b, cpu_regs.a,
						cpu_regs.ix, cpu_regs.iy, ret_pc};
					if (!take_nmi && s_q.ill_pend) begin
						s_d.ill_pend = 1'b0;
					end else if (!take_nmi && s_q.swi_pend) begin
						s_d.swi_pend = 1'b0;
					end
				end else if (rti_req) begin
					s_d.st = ST_POP;
					s_d.cnt = '0;
					s_d.sp = cpu_regs.sp;
				end
			end
			ST_PUSH: begin
				// One byte per cycle at falling addresses
				s_d.mem.we = 1'b1;
				s_d.mem.addr = s_q.sp - {12'h0, s_q.cnt};
				s_d.mem.wdata = s_q.stk[s_q.cnt];
				s_d.cnt = s_q.cnt + CNT_STEP;
				if (s_q.cnt == PUSH_LAST) begin
					s_d.st = ST_VECH;
					s_d.sp = s_q.sp - STACK_SPAN;
					s_d.i = 1'b1;
					if (s_q.take_x) begin
						s_d.x = 1'b1;
					end
				end
			end
			ST_VECH: begin
				s_d.mem.re = 1'b1;
				s_d.mem.addr = s_q.vec;
				s_d.st = ST_VECL;
			end
			ST_VECL: begin
				s_d.mem.re = 1'b1;
				s_d.mem.addr = s_q.vec + VEC_STEP;
				s_d.st = ST_VDONE;
			end
			ST_VDONE: begin
				s_d.vec_hi = mem_rdata;
				s_d.st = ST_VLAST;
			end
			ST_VLAST: begin
				s_d.new_pc = {s_q.vec_hi, mem_rdata};
				s_d.take_done = 1'b1;
				s_d.st = ST_IDLE;
			end
			ST_POP: begin
				// Reads run upward; data lands two cycles later
				if (s_q.cnt < POP_READS) begin
					s_d.mem.re = 1'b1;
					s_d.mem.addr = s_q.sp + {12'h0, s_q.cnt} + VEC_STEP;
				end
				if (s_q.cnt >= POP_FIRST_DATA) begin
					s_d.stk[POP_LAST - s_q.cnt] = mem_rdata;
				end
				s_d.cnt = s_q.cnt + CNT_STEP;
				if (s_q.cnt == POP_LAST) begin
					s_d.st = ST_IDLE;
					s_d.pop_done = 1'b1;
					s_d.sp = s_q.sp + STACK_SPAN;
					s_d.i = s_q.stk[STK_CCR][CCR_I_BIT];
					s_d.x = s_q.stk[STK_CCR][CCR_X_BIT];
				end
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase

		// Clock monitor and watchdog restart from their own vectors
		if (reset_class) begin
			s_d.st = ST_VECH;
			s_d.vec = clock_fail && clock_monitor_en ?
				VEC_CLKMON : VEC_WDOG;
			s_d.i = 1'b1;
			s_d.x = 1'b1;
		end

		// Trap requests are sticky; a new one beats the clear
		if (op_fetch.valid && !op_legal(op_fetch.page, op_fetch.code)) begin
			s_d.ill_pend = 1'b1;
			s_d.ill_addr = op_fetch.addr;
		end
		if (swi_done && !swi_now) begin
			s_d.swi_pend = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s_q <= IVS_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ******************************
	// Outputs
	// ******************************
	assign mem_o = s_q.mem;
	assign take_done = s_q.take_done;
	assign new_pc = s_q.new_pc;
	assign new_sp = s_q.sp;
	assign pop_done = s_q.pop_done;
	assign mask_i = s_q.i;
	assign mask_x = s_q.x;
	assign reg_rdata = s_q.rdata;
	assign pop_regs = '{pc: {s_q.stk[STK_PCH], s_q.stk[STK_PCL]},
		iy: {s_q.stk[STK_IYH], s_q.stk[STK_IYL]},
		ix: {s_q.stk[STK_IXH], s_q.stk[STK_IXL]},
		a: s_q.stk[STK_A], b: s_q.stk[STK_B], condition_code_reg: s_q.stk[STK_CCR],
		sp: s_q.sp};

	// ******************************
	// Assertions
	// ******************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	// Nine back-to-back stack writes
	sequence s_push9;
		mem_o.we [*8] ##1 mem_o.we ##1 !mem_o.we;
	endsequence

	// Two vector reads, high then low
	sequence s_vec_reads;
		(mem_o.re && mem_o.addr == s_q.vec) ##1
		(mem_o.re && mem_o.addr == s_q.vec + VEC_STEP);
	endsequence

	a_push_frame: assert property (
		$rose(s_q.st == ST_PUSH) && !reset_class |=> s_push9)
		else $error("stacking did not write nine bytes");

	a_ccr_slot: assert property (
		s_q.st == ST_PUSH && s_q.cnt == PUSH_LAST && !reset_class |=>
		mem_o.we && mem_o.addr == s_q.sp + VEC_STEP &&
		mem_o.wdata == $past(s_q.stk[STK_CCR]))
		else $error("condition codes not at stack pointer minus eight");

	a_entry_masks: assert property (
		s_q.st == ST_PUSH && s_q.cnt == PUSH_LAST |=>
		s_q.i && (s_q.x == ($past(s_q.x) | $past(s_q.take_x))))
		else $error("masks wrong after condition codes stacked");

	a_vector_fetch: assert property (
		$rose(s_q.st == ST_VECH) && !reset_class |=> s_vec_reads ##2
		take_done)
		else $error("vector fetch sequence broken");

	a_mask_holds: assert property (
		s_q.st == ST_IDLE && boundary && s_q.i && !take_nmi &&
		!s_q.ill_pend && !s_q.swi_pend && !swi_done && !reset_class |=>
		s_q.st == ST_IDLE)
		else $error("maskable source taken while masked");

	a_pin_first: assert property (
		s_q.st == ST_IDLE && boundary && take_nmi && !reset_class |=>
		s_q.vec == VEC_NMI && s_q.take_x)
		else $error("nonmaskable pin lost priority");

	a_promote_lock: assert property (
		reg_we && reg_addr == ADDR_PROMOTE && !s_q.i |=>
		s_q.psel == $past(s_q.psel))
		else $error("promote code changed while unmasked");

	a_nmi_no_set: assert property (
		s_q.st == ST_IDLE && tap_req && !s_q.x && !reset_class &&
		!(boundary && take_any) |=> !s_q.x)
		else $error("software set the nmi mask bit");

	a_pop_start: assert property (
		$rose(s_q.st == ST_POP) |=> mem_o.re &&
		mem_o.addr == s_q.sp + VEC_STEP)
		else $error("return did not start at stack pointer plus one");

	a_restore: assert property (
		pop_done |-> mask_i == pop_regs.condition_code_reg[CCR_I_BIT] &&
		mask_x == pop_regs.condition_code_reg[CCR_X_BIT])
		else $error("masks not restored on return");

	a_reset_masks: assert property (
		$past(srst) |-> s_q.i && s_q.x && s_q.st == ST_VECH &&
		s_q.vec == VEC_RESET && s_q.psel == PROMOTE_RST)
		else $error("reset state wrong");

endmodule

`default_nettype wire

// File: design/ivs_pkg.sv
// Constants and types for the interrupt vectoring and stacking block
package ivs_pkg;

	// ******************************
	// Register port map
	// ******************************
	localparam logic [7:0] ADDR_PROMOTE = 8'h3C;
	localparam logic [7:0] ADDR_STATUS = 8'h3D;
	localparam logic [3:0] PROMOTE_RST = 4'h5;
	localparam int PSEL_MSB = 3;

	// ******************************
	// Condition code bits and vectors
	// ******************************
	localparam int CCR_X_BIT = 6;
	localparam int CCR_I_BIT = 4;
	localparam logic [15:0] VEC_RESET = 16'hFFFE;
	localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
	localparam logic [15:0] VEC_WDOG = 16'hFFFA;
	localparam logic [15:0] VEC_ILLEGAL = 16'hFFF8;
	localparam logic [15:0] VEC_SWTRAP = 16'hFFF6;
	localparam logic [15:0] VEC_NMI = 16'hFFF4;
	localparam logic [15:0] VEC_MASK_TOP = 16'hFFF2;
	localparam logic [15:0] VEC_STEP = 16'h0001;
	localparam int N_MASK = 15;

	// ******************************
	// Promote code decoding
	// ******************************
	localparam logic [3:0] PSEL_LOW_LAST = 4'h4;
	localparam logic [3:0] PSEL_PIN_A = 4'h5;
	localparam logic [3:0] PSEL_PIN_B = 4'h6;
	localparam logic [3:0] PSEL_LOW_OFS = 4'hA;
	localparam logic [3:0] PSEL_HIGH_OFS = 4'h6;

	// ******************************
	// Stack frame layout and counts
	// ******************************
	localparam int STK_PCL = 0, STK_PCH = 1, STK_IYL = 2, STK_IYH = 3;
	localparam int STK_IXL = 4, STK_IXH = 5, STK_A = 6, STK_B = 7, STK_CCR = 8;
	localparam logic [3:0] PUSH_LAST = 4'h8;
	localparam logic [3:0] POP_READS = 4'h9;
	localparam logic [3:0] POP_FIRST_DATA = 4'h2;
	localparam logic [3:0] POP_LAST = 4'hA;
	localparam logic [3:0] CNT_STEP = 4'h1;
	localparam logic [15:0] STACK_SPAN = 16'h0009;
	localparam logic [255:0] OPMAP_ALL_LEGAL = {256{1'b1}};

	// ******************************
	// Types
	// ******************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_PUSH = 3'h1,
		ST_VECH = 3'h3,
		ST_VECL = 3'h2,
		ST_VDONE = 3'h6,
		ST_VLAST = 3'h7,
		ST_POP = 3'h4
	} ivs_st_t;

	typedef struct packed {
		logic [15:0] pc;
		logic [15:0] iy;
		logic [15:0] ix;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] condition_code_reg;
		logic [15:0] sp;
	} ivs_regs_t;

	typedef struct packed {
		logic re;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} ivs_mem_t;

	typedef struct packed {
		logic valid;
		logic [1:0] page;
		logic [7:0] code;
		logic [15:0] addr;
	} ivs_opf_t;

	typedef struct packed {
		logic tick, cap1, cap2, cap3, cmp1, cmp2, cmp3, cmp4, cap4cmp5;
		logic wrap, pulse_ovf, pulse_edge, spi_done;
		logic tx_done, tx_empty, idle_line, overrun, rx_full;
	} ivs_flags_t;

	typedef struct packed {
		logic periodic_tick_irq_en, capture1_irq_en, capture2_irq_en;
		logic capture3_irq_en, compare1_irq_en, compare2_irq_en;
		logic compare3_irq_en, compare4_irq_en, capture4_compare5_irq_en;
		logic timer_wrap_irq_en, pulse_overflow_irq_en, pulse_edge_irq_en;
		logic serial_periph_irq_en, tx_done_irq_en, tx_empty_irq_en;
		logic idle_line_irq_en, rx_irq_en;
	} ivs_en_t;

	typedef struct packed {
		ivs_st_t st;
		logic [3:0] cnt;
		logic [8:0][7:0] stk;
		logic [15:0] sp;
		logic [15:0] vec;
		logic [15:0] new_pc;
		logic [7:0] vec_hi;
		logic [7:0] rdata;
		ivs_mem_t mem;
		logic i, x, take_x, take_done, pop_done, ill_pend, swi_pend;
		logic [15:0] ill_addr;
		logic [3:0] psel;
		logic [1:0] irq_s;
		logic [1:0] nonmaskable_irq_pin_s;
	} ivs_state_t;

	// Reset starts a fetch of the reset vector with both masks set
	localparam ivs_state_t IVS_RST = '{st: ST_VECH, cnt: '0, stk: '0,
		sp: '0, vec: VEC_RESET, new_pc: '0, vec_hi: '0, rdata: '0,
		mem: '0, i: 1'h1, x: 1'h1, take_x: 1'h0, take_done: 1'h0,
		pop_done: 1'h0, ill_pend: 1'h0, swi_pend: 1'h0, ill_addr: '0,
		psel: PROMOTE_RST, irq_s: 2'h3, nonmaskable_irq_pin_s: 2'h3};

endpackage

// File: verif/ivs_mem_model.sv
// Byte memory on the stacking and vector bus of the block
`timescale 1ns/10ps
`default_nettype none

module ivs_mem_model import ivs_pkg::*; (
	// Clock
	input wire logic clk_sys,
	// Bus from the block
	input wire ivs_mem_t mem_i,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:65535];

	// Every vector pair points at 80xx, xx being its own low byte
	initial begin
		for (int a = 0; a < 65536; a++) begin
			mem[a] = a[0] ? 8'(a - 1) : 8'h80;
		end
	end

	// Data only in the cycle after a read, a toggling pattern otherwise
	always @(posedge clk_sys) begin
		if (mem_i.we) begin
			mem[mem_i.addr] <= mem_i.wdata;
		end
		rdata <= mem_i.re ? mem[mem_i.addr] : ~rdata;
	end
endmodule
`default_nettype wire

// File: verif/test_ivs_core.sv
// Self-checking bench for the interrupt vectoring and stacking block
`timescale 1ns/10ps
`default_nettype none

module test_ivs_core import ivs_pkg::*;;
	localparam logic [255:0] ILL = ~(256'h1 << 8'h41);
	localparam ivs_regs_t REGS = '{pc: 16'h1234, iy: 16'h5678,
		ix: 16'h9ABC, a: 8'hDE, b: 8'hF0, condition_code_reg: 8'h00, sp: 16'h01FF};
	logic clk_sys, srst, instr_done, swi_done, rti_req, tap_req;
	logic take_done, pop_done, mask_i, mask_x, irq_n, nonmaskable_irq_pin_n;
	logic reg_we, reg_re, watchdog_fail, watchdog_disable;
	logic clock_fail, clock_monitor_en;
	logic [7:0] tap_data, mem_rdata, reg_addr, reg_wdata, reg_rdata;
	logic [15:0] new_pc, new_sp;
	ivs_regs_t cpu_regs, pop_regs;
	ivs_opf_t op_fetch;
	ivs_mem_t mem_o;
	ivs_flags_t pflags;
	ivs_en_t pen;
	int failures, tests_run;

	ivs_core #(.OPMAP_P0(ILL), .OPMAP_P1(ILL), .OPMAP_P2(ILL),
		.OPMAP_P3(ILL)) i_dut (.clk_sys(clk_sys), .srst(srst),
		.instr_done(instr_done), .swi_done(swi_done), .rti_req(rti_req),
		.tap_req(tap_req), .tap_data(tap_data), .cpu_regs(cpu_regs),
		.op_fetch(op_fetch), .mem_o(mem_o), .mem_rdata(mem_rdata),
		.take_done(take_done), .new_pc(new_pc), .new_sp(new_sp),
		.pop_done(pop_done), .pop_regs(pop_regs), .mask_i(mask_i),
		.mask_x(mask_x), .irq_n(irq_n), .nonmaskable_irq_pin_n(nonmaskable_irq_pin_n), .pflags(pflags),
		.pen(pen), .watchdog_fail(watchdog_fail),
		.watchdog_disable(watchdog_disable), .clock_fail(clock_fail),
		.clock_monitor_en(clock_monitor_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
		.reg_rdata(reg_rdata));

	ivs_mem_model i_mem (.clk_sys(clk_sys), .mem_i(mem_o),
		.rdata(mem_rdata));

	// ****************************************
	// Access and compare tasks
	// ****************************************
	task automatic chk(input string what, input logic [15:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_regs(input ivs_regs_t exp, got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("ERROR restored regs expected %h seen %h", exp, got);
		end
	endtask

	task automatic masks(input logic ei, ex);
		chk("global mask", {15'h0000, ei}, {15'h0000, mask_i});
		chk("nmi mask", {15'h0000, ex}, {15'h0000, mask_x});
	endtask

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'h1;
		@(posedge clk_sys);
		reg_we <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_re <= 1'h1;
		@(posedge clk_sys);
		reg_re <= 1'h0;
		#1;
		chk("register read", {8'h00, exp}, {8'h00, reg_rdata});
	endtask

	task automatic tap(input logic [7:0] d);
		@(posedge clk_sys);
		tap_req <= 1'h1;
		tap_data <= d;
		@(posedge clk_sys);
		tap_req <= 1'h0;
		@(posedge clk_sys);
		#1;
	endtask

	// Zero expected means no entry may finish inside the window
	task automatic wait_take(input logic [15:0] exp);
		logic [15:0] got;
		got = 16'h0000;
		for (int i = 0; i < 40 && got == 16'h0000; i++) begin
			@(posedge clk_sys);
			#1;
			if (take_done === 1'h1) got = new_pc;
		end
		chk("handler address", exp, got);
	endtask

	task automatic boundary(input logic sw, input logic [15:0] exp);
		@(posedge clk_sys);
		instr_done <= !sw;
		swi_done <= sw;
		@(posedge clk_sys);
		instr_done <= 1'h0;
		swi_done <= 1'h0;
		wait_take(exp);
	endtask

	task automatic fail_pulse(input logic wd, ck, input logic [15:0] exp);
		@(posedge clk_sys);
		watchdog_fail <= wd;
		clock_fail <= ck;
		@(posedge clk_sys);
		watchdog_fail <= 1'h0;
		clock_fail <= 1'h0;
		wait_take(exp);
	endtask

	task automatic chk_stack();
		logic [7:0] e [9];
		e = '{REGS.pc[7:0], REGS.pc[15:8], REGS.iy[7:0], REGS.iy[15:8],
			REGS.ix[7:0], REGS.ix[15:8], REGS.a, REGS.b, REGS.condition_code_reg};
		for (int k = 0; k < 9; k++) begin
			chk("stack byte", {8'h00, e[k]}, {8'h00, i_mem.mem[REGS.sp - k]});
		end
		chk("stack pointer", REGS.sp - 16'h0009, new_sp);
	endtask

	// ****************************************
	// Clock and main sequence
	// ****************************************
	initial begin
		clk_sys = 1'h0;
		forever #50 clk_sys = ~clk_sys;
	end

	// Reset, then every entry kind, return and register access
	initial begin
		{srst, irq_n, nonmaskable_irq_pin_n, watchdog_disable} = 4'hF;
		{instr_done, swi_done, rti_req, tap_req, reg_we, reg_re} = 6'h00;
		{watchdog_fail, clock_fail, clock_monitor_en} = 3'h0;
		{tap_data, reg_addr, reg_wdata} = 24'h000000;
		cpu_regs = REGS;
		op_fetch = '0;
		pflags = '0;
		pen = '1;
		failures = 0;
		tests_run = 0;
		repeat (10) @(posedge clk_sys);
		srst <= 1'h0;
		wait_take(16'h80FE);
		masks(1'h1, 1'h1);
		rd(ADDR_STATUS, 8'hC0);
		rd(ADDR_PROMOTE, 8'h05);
		wr(ADDR_PROMOTE, 8'h08);
		rd(ADDR_PROMOTE, 8'h08);
		rd(8'h10, 8'h00);
		pflags.tick <= 1'h1;
		boundary(1'h0, 16'h0000);
		tap(8'h00);
		tap(8'h40);
		masks(1'h0, 1'h0);
		wr(ADDR_PROMOTE, 8'h05);
		rd(ADDR_PROMOTE, 8'h08);
		wait_take(16'h0000);
		pflags.cap1 <= 1'h1;
		boundary(1'h0, 16'h80EE);
		chk_stack();
		masks(1'h1, 1'h0);
		pflags <= '0;
		@(posedge clk_sys);
		cpu_regs.sp <= new_sp;
		rti_req <= 1'h1;
		@(posedge clk_sys);
		rti_req <= 1'h0;
		cpu_regs.sp <= REGS.sp;
		for (int i = 0; i < 30 && pop_done !== 1'h1; i++) begin
			@(posedge clk_sys);
			#1;
		end
		chk("return done", 16'h0001, {15'h0000, pop_done});
		chk_regs(REGS, pop_regs);
		masks(1'h0, 1'h0);
		// Each flag alone, first with enables off, then on
		for (int k = 0; k < 18; k++) begin
			pflags <= ivs_flags_t'(18'h00001 << k);
			pen <= '0;
			boundary(1'h0, 16'h0000);
			pen <= '1;
			boundary(1'h0, {8'h80, k > 4 ?
				8'(8'hF0 - 2 * (17 - k)) : 8'hD6});
			pflags <= '0;
			tap(8'h00);
		end
		tap(8'h10);
		boundary(1'h1, 16'h80F6);
		masks(1'h1, 1'h0);
		wr(ADDR_PROMOTE, 8'h05);
		tap(8'h00);
		irq_n <= 1'h0;
		pflags.tick <= 1'h1;
		repeat (3) @(posedge clk_sys);
		boundary(1'h0, 16'h80F2);
		irq_n <= 1'h1;
		pflags <= '0;
		tap(8'h00);
		nonmaskable_irq_pin_n <= 1'h0;
		irq_n <= 1'h0;
		repeat (3) @(posedge clk_sys);
		boundary(1'h0, 16'h80F4);
		masks(1'h1, 1'h1);
		nonmaskable_irq_pin_n <= 1'h1;
		irq_n <= 1'h1;
		// One illegal code on each page, taken with both masks set
		for (int p = 0; p < 4; p++) begin
			@(posedge clk_sys);
			op_fetch <= '{1'h1, 2'(p), 8'h41, 16'h2340 + 16'(p)};
			@(posedge clk_sys);
			op_fetch.valid <= 1'h0;
			boundary(1'h0, 16'h80F8);
			chk("trap return", 16'h2340 + 16'(p),
				{i_mem.mem[REGS.sp - 1], i_mem.mem[REGS.sp]});
		end
		fail_pulse(1'h1, 1'h1, 16'h0000);
		watchdog_disable <= 1'h0;
		fail_pulse(1'h1, 1'h0, 16'h80FA);
		clock_monitor_en <= 1'h1;
		fail_pulse(1'h1, 1'h1, 16'h80FC);
		masks(1'h1, 1'h1);
		close_out();
	end
endmodule
`default_nettype wire
